// ---- strap_cfg_pkg.sv ----
`default_nettype none
package strap_cfg_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
  // Initialization window length in milliseconds and in clock cycles.
  localparam int unsigned WINDOW_MS = 250;
  localparam int unsigned WINDOW_CYCLES = WINDOW_MS * CLK_PER_MS;
  // One step of staggered spindle start, in seconds and in clock cycles.
  localparam int unsigned SPIN_STEP_S = 12;
  localparam int unsigned SPIN_STEP_CYCLES = SPIN_STEP_S * CLK_HZ;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int unsigned ID_W = 4;
  localparam int unsigned OPT_W = 5;

  // Option strap positions inside the option vector.
  localparam int unsigned OPT_DELAYED = 0;
  localparam int unsigned OPT_HOST = 1;
  localparam int unsigned OPT_WPROT = 2;
  localparam int unsigned OPT_PARITY = 3;
  localparam int unsigned OPT_TERM = 4;

  // ==========================================================
  // Register map (byte addresses) and fields
  // ==========================================================
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_CONTROL = 12'h004;

  localparam int unsigned ST_ID_LSB = 0;
  localparam int unsigned ST_WPROT = 4;
  localparam int unsigned ST_PARITY = 5;
  localparam int unsigned ST_TERM = 6;
  localparam int unsigned ST_DELAYED = 7;
  localparam int unsigned ST_HOST = 8;
  localparam int unsigned ST_WINDOW = 9;
  localparam int unsigned ST_SPIN = 10;
  localparam int unsigned ST_VALID = 11;
  localparam int unsigned ST_STATE_LSB = 12;

  localparam int unsigned CTL_RESTART = 0;
  localparam int unsigned CTL_START_UNIT = 1;

  // ==========================================================
  // Reset values of the held configuration
  // ==========================================================
  localparam logic [ID_W-1:0] RST_ID = 4'h0;
  localparam logic [OPT_W-1:0] RST_OPT = 5'h08;

  // Spindle start sequencer states.
  typedef enum logic [3:0] {
    SP_WINDOW = 4'b0001,
    SP_DELAY = 4'b0010,
    SP_HOST_WAIT = 4'b0100,
    SP_RUN = 4'b1000
  } spin_state_t;

endpackage : strap_cfg_pkg
`default_nettype wire

// ---- strap_sync.sv ----
`default_nettype none
module strap_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // ==========================================================
  // Two-stage synchroniser
  // ==========================================================
  // The first stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_one <= '1;
      sync_out <= '1;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule : strap_sync
`default_nettype wire

// ---- disk_strap_config_sampler.sv ----
// The APB slave port and the register addresses are this design's own decisions.
`default_nettype none
// Notes on behaviour
// - Two ID headers combine by bitwise OR.
// - ID inputs read only inside 250 ms window.
// - Grounded input is one; open is zero.
// - Reference outputs grounded only during window.
// - After window ID inputs ignored, ID held.
// - ID weights 8,4,2,1 for bits three..zero.
// - No start straps: spindle starts immediately.
// - Host-start strap: wait for Start Unit.
// - Delayed strap only: wait ID times 12 s.
// - Write-protect strap refuses all medium writes.
// - Parity strap enables parity error reporting.
// - Termination strap enables on-board terminators.
module disk_strap_config_sampler
  import strap_cfg_pkg::*;
#(
  parameter int unsigned WINDOW_LEN = WINDOW_CYCLES,
  parameter int unsigned SPIN_STEP_LEN = SPIN_STEP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Strap pins, low when a jumper grounds them.
  input wire logic [ID_W-1:0] primary_id_header_n,
  input wire logic [ID_W-1:0] auxiliary_id_header_n,
  input wire logic delayed_start_strap_n,
  input wire logic host_start_strap_n,
  input wire logic write_protect_strap_n,
  input wire logic parity_report_strap_n,
  input wire logic bus_end_load_strap_n,
  // Open-drain ID reference pins.
  output logic [ID_W-1:0] id_ref_out,
  output logic [ID_W-1:0] id_ref_oe,
  // Command decoder and drive control.
  input wire logic drive_reset,
  input wire logic start_unit_cmd,
  output logic [ID_W-1:0] bus_id,
  output logic config_valid,
  output logic init_window,
  output logic spindle_run,
  output logic write_refuse,
  output logic parity_report_en,
  output logic term_enable
);

  localparam int unsigned WIN_W = $clog2(WINDOW_LEN + 1);
  localparam int unsigned STEP_W = $clog2(SPIN_STEP_LEN + 1);
  localparam int unsigned PIN_W = 2 * ID_W + OPT_W;
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WINDOW_LEN - 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(SPIN_STEP_LEN - 1);

  // A grounded pin reads as an asserted bit.
  function automatic logic [PIN_W-1:0] grounded(input logic [PIN_W-1:0] pins);
    grounded = ~pins;
  endfunction : grounded

  // ==========================================================
  // Pin synchronisation
  // ==========================================================
  logic [PIN_W-1:0] raw_pins;
  logic [PIN_W-1:0] sync_pins;
  logic [PIN_W-1:0] asserted;
  logic [ID_W-1:0] id_primary;
  logic [ID_W-1:0] id_auxiliary;
  logic [ID_W-1:0] id_sample;
  logic [OPT_W-1:0] opt_sample;

  assign raw_pins = {bus_end_load_strap_n, parity_report_strap_n, write_protect_strap_n,
                     host_start_strap_n, delayed_start_strap_n,
                     auxiliary_id_header_n, primary_id_header_n};

  strap_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_pins),
    .sync_out(sync_pins)
  );

  // Decode the synchronised pins and merge the two ID headers.
  assign asserted = grounded(sync_pins);
  assign id_primary = asserted[ID_W-1:0];
  assign id_auxiliary = asserted[2*ID_W-1:ID_W];
  // Bit three weighs eight down to bit zero weighing one.
  assign id_sample = id_primary | id_auxiliary;
  assign opt_sample = asserted[PIN_W-1:2*ID_W];

  // ==========================================================
  // APB slave
  // ==========================================================
  logic apb_access;
  logic apb_write;
  logic addr_ok;
  logic soft_restart;
  logic soft_start;
  logic [31:0] status_word;
  logic [31:0] next_prdata;
  logic [OPT_W-1:0] held_opt;
  spin_state_t state;

  // Registers answer with no wait states.
  assign pready = 1'b1;
  assign apb_access = psel && penable;
  assign apb_write = apb_access && pwrite;
  assign addr_ok = (paddr == ADDR_STATUS) || (paddr == ADDR_CONTROL);
  assign pslverr = apb_access && !addr_ok;
  assign soft_restart = apb_write && (paddr == ADDR_CONTROL) && pwdata[CTL_RESTART];
  assign soft_start = apb_write && (paddr == ADDR_CONTROL) && pwdata[CTL_START_UNIT];

  // Status word assembled from the held configuration and sequencer.
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_ID_LSB +: ID_W] = bus_id;
    status_word[ST_WPROT] = write_refuse;
    status_word[ST_PARITY] = parity_report_en;
    status_word[ST_TERM] = term_enable;
    status_word[ST_DELAYED] = held_opt[OPT_DELAYED];
    status_word[ST_HOST] = held_opt[OPT_HOST];
    status_word[ST_WINDOW] = init_window;
    status_word[ST_SPIN] = spindle_run;
    status_word[ST_VALID] = config_valid;
    status_word[ST_STATE_LSB +: 4] = state;
  end

  // Read data is captured in the setup cycle and stands through the access.
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      next_prdata = (paddr == ADDR_STATUS) ? status_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ==========================================================
  // Initialization window
  // ==========================================================
  logic restart;
  logic [WIN_W-1:0] win_count;
  logic [WIN_W-1:0] next_win_count;
  logic win_open;
  logic next_win_open;
  logic win_end;

  // A drive reset from the pin or from software reopens the window.
  assign restart = drive_reset || soft_restart;
  assign win_end = win_open && (win_count == WIN_LAST);

  // The window opens at reset release and lasts the full count.
  always_comb begin
    next_win_count = win_count;
    next_win_open = win_open;
    if (restart) begin
      next_win_count = '0;
      next_win_open = 1'b1;
    end else if (win_end) begin
      next_win_open = 1'b0;
    end else if (win_open) begin
      next_win_count = win_count + WIN_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_count <= '0;
      win_open <= 1'b1;
    end else begin
      win_count <= next_win_count;
      win_open <= next_win_open;
    end
  end

  assign init_window = win_open;
  // References are pulled to ground only while the window is open.
  assign id_ref_out = '0;
  assign id_ref_oe = {ID_W{win_open}};

  // ==========================================================
  // Configuration capture
  // ==========================================================
  logic [ID_W-1:0] held_id;
  logic [ID_W-1:0] next_held_id;
  logic [OPT_W-1:0] next_held_opt;
  logic held_valid;
  logic next_held_valid;

  // The pattern is sampled at the window's last cycle, after the outside
  // source has had the whole window to settle it.
  always_comb begin
    next_held_id = held_id;
    next_held_opt = held_opt;
    next_held_valid = held_valid;
    if (restart) begin
      next_held_valid = 1'b0;
    end else if (win_end) begin
      next_held_id = id_sample;
      next_held_opt = opt_sample;
      next_held_valid = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_id <= RST_ID;
      held_opt <= RST_OPT;
      held_valid <= 1'b0;
    end else begin
      held_id <= next_held_id;
      held_opt <= next_held_opt;
      held_valid <= next_held_valid;
    end
  end

  assign bus_id = held_id;
  assign config_valid = held_valid;
  assign write_refuse = held_opt[OPT_WPROT];
  assign parity_report_en = held_opt[OPT_PARITY];
  assign term_enable = held_opt[OPT_TERM];

  // ==========================================================
  // Spindle start sequencer
  // ==========================================================
  spin_state_t next_state;
  logic [STEP_W-1:0] step_count;
  logic [STEP_W-1:0] next_step_count;
  logic [ID_W-1:0] steps_left;
  logic [ID_W-1:0] next_steps_left;
  logic start_req;

  assign start_req = start_unit_cmd || soft_start;

  // Chooses the start policy from the straps caught at window end.
  always_comb begin
    next_state = state;
    next_step_count = step_count;
    next_steps_left = steps_left;
    case (state)
      SP_WINDOW: begin
        if (win_end) begin
          if (opt_sample[OPT_HOST]) begin
            next_state = SP_HOST_WAIT;
          end else if (opt_sample[OPT_DELAYED] && (id_sample != '0)) begin
            next_state = SP_DELAY;
            next_step_count = '0;
            next_steps_left = id_sample;
          end else begin
            next_state = SP_RUN;
          end
        end
      end
      SP_DELAY: begin
        if (start_req) begin
          next_state = SP_RUN;
        end else if (step_count == STEP_LAST) begin
          next_step_count = '0;
          next_steps_left = steps_left - ID_W'(1);
          if (steps_left == ID_W'(1)) begin
            next_state = SP_RUN;
          end
        end else begin
          next_step_count = step_count + STEP_W'(1);
        end
      end
      SP_HOST_WAIT: begin
        if (start_req) begin
          next_state = SP_RUN;
        end
      end
      SP_RUN: begin
        next_state = SP_RUN;
      end
      default: begin
        next_state = SP_WINDOW;
      end
    endcase
    if (restart) begin
      next_state = SP_WINDOW;
      next_step_count = '0;
      next_steps_left = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SP_WINDOW;
      step_count <= '0;
      steps_left <= '0;
    end else begin
      state <= next_state;
      step_count <= next_step_count;
      steps_left <= next_steps_left;
    end
  end

  assign spindle_run = (state == SP_RUN);

endmodule : disk_strap_config_sampler
`default_nettype wire

// ---- strap_jumper_model.sv ----
`default_nettype none
// ==========================================================
// Jumper plugs on the primary header, switching circuit on the auxiliary one.
module strap_jumper_model
  import strap_cfg_pkg::*;
(
  input wire logic [ID_W-1:0] id_ref_out,
  input wire logic [ID_W-1:0] id_ref_oe,
  input wire logic [ID_W-1:0] jumpers,
  input wire logic ext_en,
  input wire logic [ID_W-1:0] ext_id,
  output logic [ID_W-1:0] primary_id_header_n,
  output logic [ID_W-1:0] auxiliary_id_header_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // A jumper ties its pin to the grounded reference, otherwise the pull-up wins.
  assign primary_id_header_n = ~(jumpers & id_ref_oe) | id_ref_out;
  // The switching circuit holds a steady low per set bit, then lets go to the pull-up.
  assign auxiliary_id_header_n = ext_en ? ~ext_id : 4'hF;
endmodule : strap_jumper_model
`default_nettype wire

// ---- disk_strap_config_sampler_checker.sv ----
`default_nettype none
// ==========================================================
// Window, hold and bus checks seen at the block's ports.
module disk_strap_config_sampler_checker
  import strap_cfg_pkg::*;
#(
  parameter int unsigned WINDOW_LEN = WINDOW_CYCLES,
  parameter int unsigned SPIN_STEP_LEN = SPIN_STEP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ID_W-1:0] id_ref_out,
  input wire logic [ID_W-1:0] id_ref_oe,
  input wire logic drive_reset,
  input wire logic start_unit_cmd,
  input wire logic [ID_W-1:0] bus_id,
  input wire logic config_valid,
  input wire logic init_window,
  input wire logic spindle_run,
  input wire logic write_refuse,
  input wire logic parity_report_en,
  input wire logic term_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] win_cnt;
  logic [31:0] spin_cnt;
  logic wr_ctl;
  logic restart;
  logic su;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Restart and start requests from the pins or from a control write.
  assign wr_ctl = psel && penable && pwrite && paddr == ADDR_CONTROL;
  assign restart = drive_reset || (wr_ctl && pwdata[CTL_RESTART]);
  assign su = start_unit_cmd || (wr_ctl && pwdata[CTL_START_UNIT]);
  // Cycles inside the current window and cycles since it closed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt <= '0;
      spin_cnt <= '0;
    end else begin
      win_cnt <= restart ? '0 : win_cnt + {31'h0, init_window};
      spin_cnt <= init_window ? '0 : spin_cnt + 1;
    end
  end
  a_ref_window: assert property (id_ref_oe == {ID_W{init_window}} && id_ref_out == '0)
    else $error("reference pins driven outside the window");
  a_window_len: assert property ($fell(init_window) |-> win_cnt == WINDOW_LEN)
    else $error("window length differs");
  a_restart_opens: assert property (restart |=> init_window && !config_valid)
    else $error("restart did not open the window");
  a_held_config: assert property (!init_window |=> $stable({bus_id, write_refuse, parity_report_en, term_enable}))
    else $error("held configuration changed");
  a_valid_capture: assert property ($rose(config_valid) |-> $fell(init_window))
    else $error("capture outside window end");
  a_spin_early: assert property ($rose(spindle_run) && !$fell(init_window) && !$past(su) && !$past(su, 2)
    |-> spin_cnt >= bus_id * SPIN_STEP_LEN)
    else $error("spindle started before its delay");
  a_start_unit: assert property (su && !init_window && !spindle_run && !restart |-> ##[1:2] spindle_run)
    else $error("start request ignored");
  a_slverr_map: assert property (psel && penable |-> pready && pslverr == (paddr != ADDR_STATUS && paddr != ADDR_CONTROL))
    else $error("error response wrong");
  a_slverr_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error response outside access");
  c_capture: cover property ($fell(init_window));
  c_spin: cover property ($rose(spindle_run) && !$fell(init_window));
  c_unmapped: cover property (psel && penable && pslverr);
endmodule : disk_strap_config_sampler_checker
bind disk_strap_config_sampler disk_strap_config_sampler_checker #(.WINDOW_LEN(WINDOW_LEN),
  .SPIN_STEP_LEN(SPIN_STEP_LEN)) chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .id_ref_out, .id_ref_oe, .drive_reset, .start_unit_cmd, .bus_id, .config_valid,
  .init_window, .spindle_run, .write_refuse, .parity_report_en, .term_enable);
`default_nettype wire

// ---- tb_disk_strap_config_sampler.sv ----
`default_nettype none
// ==========================================================
// Strap sampling bench: random straps, both ID headers, restarts and starts.
module tb_disk_strap_config_sampler;
  timeunit 1ns;
  timeprecision 1ps;
  import strap_cfg_pkg::*;
  localparam int unsigned WL = 20;
  localparam int unsigned SL = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_en;
  logic drive_reset, start_unit_cmd, config_valid, init_window, spindle_run;
  logic write_refuse, parity_report_en, term_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [ID_W-1:0] primary_id_header_n, auxiliary_id_header_n, id_ref_out, id_ref_oe, bus_id, jumpers, ext_id;
  logic [4:0] s;
  wire logic delayed_start_strap_n, host_start_strap_n, write_protect_strap_n;
  wire logic parity_report_strap_n, bus_end_load_strap_n;
  logic [33:0] q[$];
  logic [33:0] n;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // An installed strap pulls its pin low.
  assign {bus_end_load_strap_n, parity_report_strap_n, write_protect_strap_n, host_start_strap_n,
    delayed_start_strap_n} = ~s;
  disk_strap_config_sampler #(.WINDOW_LEN(WL), .SPIN_STEP_LEN(SL)) dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .primary_id_header_n, .auxiliary_id_header_n,
    .delayed_start_strap_n, .host_start_strap_n, .write_protect_strap_n, .parity_report_strap_n,
    .bus_end_load_strap_n, .id_ref_out, .id_ref_oe, .drive_reset, .start_unit_cmd, .bus_id, .config_valid,
    .init_window, .spindle_run, .write_refuse, .parity_report_en, .term_enable);
  strap_jumper_model model_u (.id_ref_out, .id_ref_oe, .jumpers, .ext_en, .ext_id, .primary_id_header_n,
    .auxiliary_id_header_n);
  // Free-running 50 MHz clock.
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  function automatic logic [31:0] stat(input logic [3:0] id, input logic [4:0] o, input logic [3:0] st);
    return {16'h0, st, 1'b1, st[3], 1'b0, o[1], o[0], o[4], o[3], o[2], id};
  endfunction : stat
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    q.push_back({a == ADDR_STATUS, err, e});
    apb(0, a, 32'h0);
  endtask : rd
  task automatic run_case(input int k);
    logic [4:0] o;
    logic [3:0] id;
    logic [3:0] st;
    rnd = xs(rnd);
    o = {rnd[4:2], k[1:0]};
    id = rnd[8:5] | rnd[12:9];
    st = o[1] ? 4'h4 : (o[0] && id != 0) ? 4'h2 : 4'h8;
    @(posedge pclk);
    s <= o;
    jumpers <= rnd[8:5];
    ext_id <= rnd[12:9];
    ext_en <= 1;
    if (k % 2 == 1) apb(1, ADDR_CONTROL, 32'h1);
    else if (k > 0) begin
      @(posedge pclk);
      drive_reset <= 1;
      @(posedge pclk);
      drive_reset <= 0;
    end
    repeat (2) @(negedge pclk);
    while (init_window) @(negedge pclk);
    @(posedge pclk);
    s <= ~o;
    jumpers <= ~rnd[8:5];
    ext_en <= 0;
    rd(ADDR_STATUS, stat(id, o, st), 0);
    if (st == 4'h4 || (st == 4'h2 && k[2])) begin
      if (k[3]) apb(1, ADDR_CONTROL, 32'h2);
      else begin
        @(posedge pclk);
        start_unit_cmd <= 1;
        @(posedge pclk);
        start_unit_cmd <= 0;
      end
    end else if (st == 4'h2) repeat (id * SL) @(posedge pclk);
    apb(1, ADDR_STATUS, 32'hFFFF_FFFF);
    rd(ADDR_STATUS, stat(id, o, 4'h8), 0);
  endtask : run_case
  // Compares each read with the oldest expected note.
  always @(negedge pclk) begin
    if (presetn && psel && penable && !pwrite && pready) begin
      n = q.pop_front();
      chk("prdata", prdata, n[31:0]);
      chk("pslverr", {31'h0, pslverr}, {31'h0, n[32]});
      if (n[33]) chk("ports", {24'h0, spindle_run, term_enable, parity_report_en, write_refuse, bus_id},
        {24'h0, n[10], n[6:0]});
    end
  end
  // Cuts a hung run short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  // Reset, random cases, then unmapped and write-only accesses.
  initial begin
    {psel, penable, pwrite, drive_reset, start_unit_cmd, ext_en} = '0;
    paddr = '0;
    pwdata = '0;
    s = 5'h08;
    jumpers = '0;
    ext_id = '0;
    rnd = 32'd24408;
    presetn = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    for (int k = 0; k < 16; k++) run_case(k);
    rd(12'h008, 32'h0, 1'b1);
    apb(1, 12'h00C, 32'hFFFF_FFFF);
    rd(ADDR_CONTROL, 32'h0, 1'b0);
    summarize();
  end
endmodule : tb_disk_strap_config_sampler
`default_nettype wire
